// file: amseq_consts.svh
// Timing, field positions and encodings for the converter mode sequencer.
// Assumes a 125 MHz core clock; included by every design file of the block except the package.
`ifndef AMSEQ_CONSTS_SVH
`define AMSEQ_CONSTS_SVH

`define AMSEQ_CLK_MHZ 125
// Reference power-up time in microseconds (plain default)
`define AMSEQ_REFERENCE_HELD_STATE_US 4000
`define AMSEQ_REFERENCE_HELD_STATE_CYC (`AMSEQ_REFERENCE_HELD_STATE_US * `AMSEQ_CLK_MHZ)
// Position of the oversampling option in configuration group A byte 0
`define AMSEQ_OPT_BIT 0
// Number of converters and cells handled by each of them
`define AMSEQ_NUM_CONV 3
`define AMSEQ_CELLS_PER_CONV 6
// Per-slot base time for one conversion at the fastest ratio, in cycles
`define AMSEQ_SLOT_BASE 16
// Calibration slot length relative to a measure slot
`define AMSEQ_CAL_SLOTS 1
// Filter corner codes in Hz, fast to filtered
`define AMSEQ_BW_27K 20'h06978
`define AMSEQ_BW_13K5 20'h034BC
`define AMSEQ_BW_6K8 20'h01A90
`define AMSEQ_BW_3K4 20'h00D48
`define AMSEQ_BW_1K7 20'h006A4
`define AMSEQ_BW_845 20'h0034D
`define AMSEQ_BW_422 20'h001A6
`define AMSEQ_BW_26 20'h0001A
// Oversampling ratio exponents per mode, lowest for fast
`define AMSEQ_OSR_FAST 3'h0
`define AMSEQ_OSR_FILT 3'h7

`endif

// file: amseq_pkg.sv
// Types of the converter mode sequencer.
// Assumes amseq_consts.svh for numeric values.
package amseq_pkg;

	// Eight modes, ordered by falling filter corner
	typedef enum logic [2:0] {
		AMSEQ_M27K = 3'h0,
		AMSEQ_M14K = 3'h1,
		AMSEQ_M7K = 3'h2,
		AMSEQ_M3K = 3'h3,
		AMSEQ_M2K = 3'h4,
		AMSEQ_M1K = 3'h5,
		AMSEQ_M422 = 3'h6,
		AMSEQ_M26 = 3'h7
	} amseq_mode_t;

	// Conversion command as handed over by the command decoder
	typedef struct packed {
		logic [1:0] mode_select_field;
		logic all_cells;
		logic gpio_meas;
	} amseq_cmd_t;

	// Settings handed to the converters
	typedef struct packed {
		amseq_mode_t mode;
		logic [2:0] osr_exp;
		logic [19:0] corner_hz;
	} amseq_cfg_t;

	typedef enum logic [4:0] {
		AMSEQ_STANDBY = 5'h01,
		AMSEQ_POWERUP = 5'h02,
		AMSEQ_REFHELD = 5'h04,
		AMSEQ_MEASURE = 5'h08,
		AMSEQ_CALIB = 5'h10
	} amseq_state_t;

endpackage : amseq_pkg

// file: amseq_mode_dec.sv
// Mode decoder: option bit plus command field to mode and filter settings.
// Assumes inputs chosen by the sequencer: the command being taken, else its latched copy.
`timescale 1ns/100ps
`include "amseq_consts.svh"
module amseq_mode_dec (
	input wire logic opt_i,
	input wire logic [1:0] field_i,
	output amseq_pkg::amseq_cfg_t cfg_o
);
	// Option off picks 27k/7k/422/26 style set; option on picks the others
	logic [2:0] mode_code;
	logic [19:0] corner;
	always_comb begin
		mode_code = 3'h2;
		unique case ({opt_i, field_i})
			3'h0: mode_code = 3'h6;
			3'h1: mode_code = 3'h0;
			3'h2: mode_code = 3'h2;
			3'h3: mode_code = 3'h7;
			3'h4: mode_code = 3'h5;
			3'h5: mode_code = 3'h1;
			3'h6: mode_code = 3'h3;
			3'h7: mode_code = 3'h4;
		endcase
	end
	// Corner per mode, for display by the filter configuration
	always_comb begin
		corner = `AMSEQ_BW_6K8;
		unique case (mode_code)
			3'h0: corner = `AMSEQ_BW_27K;
			3'h1: corner = `AMSEQ_BW_13K5;
			3'h2: corner = `AMSEQ_BW_6K8;
			3'h3: corner = `AMSEQ_BW_3K4;
			3'h4: corner = `AMSEQ_BW_1K7;
			3'h5: corner = `AMSEQ_BW_845;
			3'h6: corner = `AMSEQ_BW_422;
			3'h7: corner = `AMSEQ_BW_26;
		endcase
	end
	// One driver for the whole struct; the ratio exponent equals the mode code
	assign cfg_o = amseq_pkg::amseq_cfg_t'({mode_code, mode_code, corner});
endmodule : amseq_mode_dec

// file: amseq_slot_timer.sv
// Slot timer: counts one conversion slot whose length doubles per OSR step.
// Assumes start_i is a one-cycle pulse while idle.
`timescale 1ns/100ps
`include "amseq_consts.svh"
module amseq_slot_timer #(
	parameter int BASE = `AMSEQ_SLOT_BASE
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic start_i,
	input wire logic [2:0] osr_exp_i,
	output logic done_o
);
	logic [23:0] cnt_r;
	logic [23:0] cnt_nxt;
	logic [23:0] load_val;
	// Slot length grows with the oversampling ratio
	assign load_val = 24'(BASE) << osr_exp_i;
	assign cnt_nxt = start_i ? load_val :
		(cnt_r != 24'h000000) ? cnt_r - 24'h000001 : cnt_r;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			cnt_r <= 24'h000000;
		else
			cnt_r <= cnt_nxt;
	end
	assign done_o = (cnt_r == 24'h000001);
endmodule : amseq_slot_timer

// file: amseq_top.sv
// Converter mode sequencer: reference power-up, measure and calibration.
// Assumes a command decoder that pulses cmd_valid_i per conversion command.
`timescale 1ns/100ps
`include "amseq_consts.svh"
module amseq_top #(
	parameter int REFERENCE_HELD_STATE_CYC = `AMSEQ_REFERENCE_HELD_STATE_CYC,
	parameter int CELLS = `AMSEQ_CELLS_PER_CONV
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [7:0] config_group_a_byte0_i,
	input wire logic reference_keep_on_i,
	input wire logic cmd_valid_i,
	input wire amseq_pkg::amseq_cmd_t cmd_i,
	output logic ref_on_o,
	output logic [2:0] conv_en_o,
	output logic measuring_o,
	output logic calibrating_o,
	output logic busy_o,
	output logic done_o,
	output amseq_pkg::amseq_cfg_t cfg_o,
	output amseq_pkg::amseq_state_t state_o
);
	amseq_pkg::amseq_state_t state_r;
	amseq_pkg::amseq_state_t state_nxt;
	logic opt_r;
	logic [1:0] field_r;
	logic all_r;
	logic gpio_r;
	logic pend_r;
	logic [31:0] ref_cnt_r;
	logic [31:0] ref_cnt_nxt;
	logic [2:0] slot_r;
	logic [2:0] slot_nxt;
	logic slot_start_r;
	logic slot_done;
	amseq_pkg::amseq_cfg_t cfg;
	logic [2:0] conv_mask;

	// State decode
	wire in_standby = (state_r == amseq_pkg::AMSEQ_STANDBY);
	wire in_powerup = (state_r == amseq_pkg::AMSEQ_POWERUP);
	wire in_held = (state_r == amseq_pkg::AMSEQ_REFHELD);
	wire in_meas = (state_r == amseq_pkg::AMSEQ_MEASURE);
	wire in_cal = (state_r == amseq_pkg::AMSEQ_CALIB);
	wire idle = in_standby || in_held;
	wire accept = cmd_valid_i && idle;
	wire ref_done = in_powerup && (ref_cnt_r == 32'h00000001);
	wire last_slot = (slot_r == 3'(CELLS - 1));
	wire meas_end = in_meas && slot_done && last_slot;
	wire cal_end = in_cal && slot_done && last_slot;
	wire go_meas = (accept && in_held) || (ref_done && pend_r);

	// Fields of the command being taken, else the latched copy; a start from
	// the held state then shows the new mode and converters on its first
	// measure cycle instead of those of the previous command
	wire opt_sel = accept ? config_group_a_byte0_i[`AMSEQ_OPT_BIT] : opt_r;
	wire [1:0] field_sel = accept ? cmd_i.mode_select_field : field_r;
	wire gpio_sel = accept ? cmd_i.gpio_meas : gpio_r;
	wire all_sel = accept ? cmd_i.all_cells : all_r;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			opt_r <= 1'b0;
			field_r <= 2'h0;
			all_r <= 1'b0;
			gpio_r <= 1'b0;
		end else if (accept) begin
			opt_r <= config_group_a_byte0_i[`AMSEQ_OPT_BIT];
			field_r <= cmd_i.mode_select_field;
			all_r <= cmd_i.all_cells;
			gpio_r <= cmd_i.gpio_meas;
		end
	end

	amseq_mode_dec u_dec (
		.opt_i(opt_sel),
		.field_i(field_sel),
		.cfg_o(cfg)
	);

	// A command pending behind the reference power-up
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			pend_r <= 1'b0;
		else if (accept && in_standby)
			pend_r <= 1'b1;
		else if (ref_done)
			pend_r <= 1'b0;
	end

	// power-up wait
	// Keep-on alone also powers up the reference without a command
	assign ref_cnt_nxt = ((in_standby && (cmd_valid_i || reference_keep_on_i))) ?
		32'(REFERENCE_HELD_STATE_CYC) :
		(in_powerup && ref_cnt_r != 32'h00000000) ?
		ref_cnt_r - 32'h00000001 : ref_cnt_r;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			ref_cnt_r <= 32'h00000000;
		else
			ref_cnt_r <= ref_cnt_nxt;
	end

	// Sequencer state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			amseq_pkg::AMSEQ_STANDBY: begin
				if (cmd_valid_i || reference_keep_on_i)
					state_nxt = amseq_pkg::AMSEQ_POWERUP;
			end
			amseq_pkg::AMSEQ_POWERUP: begin
				if (ref_done)
					state_nxt = pend_r ? amseq_pkg::AMSEQ_MEASURE :
						(reference_keep_on_i ? amseq_pkg::AMSEQ_REFHELD :
						amseq_pkg::AMSEQ_STANDBY);
			end
			amseq_pkg::AMSEQ_REFHELD: begin
				if (cmd_valid_i)
					state_nxt = amseq_pkg::AMSEQ_MEASURE;
				else if (!reference_keep_on_i)
					state_nxt = amseq_pkg::AMSEQ_STANDBY;
			end
			amseq_pkg::AMSEQ_MEASURE: begin
				if (meas_end)
					state_nxt = amseq_pkg::AMSEQ_CALIB;
			end
			amseq_pkg::AMSEQ_CALIB: begin
				if (cal_end)
					state_nxt = reference_keep_on_i ?
						amseq_pkg::AMSEQ_REFHELD : amseq_pkg::AMSEQ_STANDBY;
			end
			default: state_nxt = amseq_pkg::AMSEQ_STANDBY;
		endcase
	end
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			state_r <= amseq_pkg::AMSEQ_STANDBY;
		else
			state_r <= state_nxt;
	end

	// Slot index walks the cells of one converter, then again to calibrate
	assign slot_nxt = (go_meas || meas_end || cal_end) ? 3'h0 :
		((in_meas || in_cal) && slot_done) ? slot_r + 3'h1 : slot_r;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			slot_r <= 3'h0;
			slot_start_r <= 1'b0;
		end else begin
			slot_r <= slot_nxt;
			slot_start_r <= go_meas || meas_end ||
				((in_meas || in_cal) && slot_done && !last_slot);
		end
	end

	amseq_slot_timer u_slot (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.start_i(slot_start_r),
		.osr_exp_i(cfg.osr_exp),
		.done_o(slot_done)
	);

	// all three converters for all cells unless gpio_meas is set; one converter otherwise
	assign conv_mask = (gpio_sel || !all_sel) ? 3'h1 : 3'h7;

	// Helper count of cycles in the present phase; it feeds only the checks
	// below, so that a wrong slot length shows even where no test times it
	logic [31:0] phase_cnt_r;
	logic [31:0] phase_len;
	assign phase_len = 32'(CELLS) *
		((32'(`AMSEQ_SLOT_BASE) << cfg.osr_exp) + 32'h00000001);
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			phase_cnt_r <= 32'h00000000;
		else if (go_meas || meas_end || cal_end)
			phase_cnt_r <= 32'h00000000;
		else if (in_meas || in_cal)
			phase_cnt_r <= phase_cnt_r + 32'h00000001;
	end

	// Registered outputs; done pulses once at calibration end
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ref_on_o <= 1'b0;
			conv_en_o <= 3'h0;
			measuring_o <= 1'b0;
			calibrating_o <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			cfg_o <= '0;
			state_o <= amseq_pkg::AMSEQ_STANDBY;
		end else begin
			ref_on_o <= !(state_nxt == amseq_pkg::AMSEQ_STANDBY);
			conv_en_o <= (state_nxt == amseq_pkg::AMSEQ_MEASURE ||
				state_nxt == amseq_pkg::AMSEQ_CALIB) ? conv_mask : 3'h0;
			measuring_o <= (state_nxt == amseq_pkg::AMSEQ_MEASURE);
			calibrating_o <= (state_nxt == amseq_pkg::AMSEQ_CALIB);
			busy_o <= !(state_nxt == amseq_pkg::AMSEQ_STANDBY ||
				state_nxt == amseq_pkg::AMSEQ_REFHELD);
			done_o <= cal_end;
			cfg_o <= cfg;
			state_o <= state_nxt;
		end
	end

	// Checks beside the logic; each names its rule on the label line
	mode_held_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		(in_meas || in_cal) && !accept |=> $stable(field_r))
		else $error("mode field changed during conversion");
	cal_after_meas_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		meas_end |=> in_cal)
		else $error("calibration did not follow measure");
	held_start_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		in_held && cmd_valid_i |=> in_meas)
		else $error("held state did not start at once");
	standby_wait_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		in_standby && cmd_valid_i |=> in_powerup [*2])
		else $error("conversion began without reference wait");
	held_exit_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		in_held && !cmd_valid_i && !reference_keep_on_i |=> in_standby)
		else $error("held state kept without keep-on");
	finish_dest_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		cal_end |=> (in_held == $past(reference_keep_on_i)) &&
		(in_held || in_standby))
		else $error("wrong state after conversion");
	conv_count_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		(measuring_o || calibrating_o) && gpio_r |-> conv_en_o == 3'h1)
		else $error("general input used more than one converter");
	all_cells_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		measuring_o && all_r && !gpio_r |-> conv_en_o == 3'h7)
		else $error("all-cell conversion not on three converters");
	mode_map_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		{opt_sel, field_sel} == 3'h3 |-> cfg.corner_hz == `AMSEQ_BW_26)
		else $error("filtered mode corner wrong");
	fast_osr_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		{opt_sel, field_sel} == 3'h1 |-> cfg.osr_exp == `AMSEQ_OSR_FAST)
		else $error("fast mode ratio not lowest");
	phase_len_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		meas_end || cal_end |-> phase_cnt_r == phase_len - 32'h00000001)
		else $error("phase length does not follow the ratio");
	ref_wait_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		in_powerup && $past(in_standby) |-> ref_cnt_r == 32'(REFERENCE_HELD_STATE_CYC))
		else $error("reference wait not loaded in full");
	held_ref_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		in_held |-> ref_on_o && !busy_o)
		else $error("reference not shown up in held state");
	refused_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		busy_o && cmd_valid_i |=> $stable(opt_r) && $stable(field_r))
		else $error("command taken during a conversion");
	done_pulse_a: assert property (@(posedge clock_i)
		disable iff (!rstn_i)
		done_o |=> !done_o)
		else $error("done held longer than one cycle");
	// Main scenarios
	cv_held: cover property (@(posedge clock_i) disable iff (!rstn_i)
		in_held ##1 in_meas);
	cv_standby_conv: cover property (@(posedge clock_i) disable iff (!rstn_i)
		in_powerup ##1 in_meas);
	cv_done: cover property (@(posedge clock_i) disable iff (!rstn_i) done_o);
	cv_gpio: cover property (@(posedge clock_i) disable iff (!rstn_i)
		measuring_o && conv_en_o == 3'h1);
	cv_keep_exit: cover property (@(posedge clock_i) disable iff (!rstn_i)
		in_held ##1 in_standby);
endmodule : amseq_top

// file: amseq_host_model.sv
// Host side model: drives config byte, keep-on and conversion commands.
// Assumes the sequencer samples its inputs on the rising clock edge.
`timescale 1ns/100ps
module amseq_host_model (
	input wire logic clock_i,
	output logic [7:0] cfg_o,
	output logic keep_on_o,
	output logic cmd_valid_o,
	output amseq_pkg::amseq_cmd_t cmd_o
);
	// Quiet host at time zero
	initial begin
		cfg_o = 8'h00;
		keep_on_o = 1'b0;
		cmd_valid_o = 1'b0;
		cmd_o = '0;
	end
	// Config writes land just after an edge
	task automatic set_cfg(input logic [7:0] b, input logic k);
		@(posedge clock_i);
		cfg_o <= b;
		keep_on_o <= k;
	endtask : set_cfg
	// Command pulse; fields inverted after so stale data never matches
	task automatic issue(input amseq_pkg::amseq_cmd_t c);
		@(posedge clock_i);
		cmd_valid_o <= 1'b1;
		cmd_o <= c;
		@(posedge clock_i);
		cmd_valid_o <= 1'b0;
		cmd_o <= ~c;
	endtask : issue
endmodule : amseq_host_model

// file: tb_top.sv
// Self-checking bench of the converter mode sequencer.
// Assumes the host model drives every command and config input.
`timescale 1ns/100ps
`include "amseq_consts.svh"
module tb_top;
	localparam int REFERENCE_HELD_STATE = 20;
	localparam int CELLS = 2;
	logic clock_i;
	logic rstn_i;
	logic [7:0] cfg_b;
	logic keep;
	logic cmd_v;
	amseq_pkg::amseq_cmd_t cmd;
	logic ref_on;
	logic [2:0] conv_en;
	logic meas;
	logic cal;
	logic busy;
	logic done;
	amseq_pkg::amseq_cfg_t cfg;
	amseq_pkg::amseq_state_t st;
	int error_cnt = 0;
	int n_tests = 0;
	// Mode per {option, field}, and corner per mode
	logic [2:0] mode_tab [8] = '{3'h6, 3'h0, 3'h2, 3'h7,
		3'h5, 3'h1, 3'h3, 3'h4};
	logic [19:0] bw_tab [8] = '{`AMSEQ_BW_27K, `AMSEQ_BW_13K5,
		`AMSEQ_BW_6K8, `AMSEQ_BW_3K4, `AMSEQ_BW_1K7,
		`AMSEQ_BW_845, `AMSEQ_BW_422, `AMSEQ_BW_26};

	amseq_top #(.REFERENCE_HELD_STATE_CYC(REFERENCE_HELD_STATE), .CELLS(CELLS)) i_dut (
		.clock_i(clock_i), .rstn_i(rstn_i),
		.config_group_a_byte0_i(cfg_b), .reference_keep_on_i(keep),
		.cmd_valid_i(cmd_v), .cmd_i(cmd), .ref_on_o(ref_on),
		.conv_en_o(conv_en), .measuring_o(meas),
		.calibrating_o(cal), .busy_o(busy), .done_o(done),
		.cfg_o(cfg), .state_o(st));
	amseq_host_model i_host (.clock_i(clock_i), .cfg_o(cfg_b),
		.keep_on_o(keep), .cmd_valid_o(cmd_v), .cmd_o(cmd));

	// Clock at 125 MHz
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic conclude();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	// Edges until measuring shows, bounded
	task automatic wait_meas(output int n);
		#1;
		n = 0;
		while (meas !== 1'b1 && n < 200) begin
			@(posedge clock_i);
			#1;
			n++;
		end
	endtask : wait_meas

	// Follow one conversion to done; phase order and length
	task automatic run_conv(input int osr, input int pre);
		int mn, cn, k, len;
		logic bad;
		mn = pre;
		len = CELLS * ((`AMSEQ_SLOT_BASE << osr) + 1);
		cn = 0;
		bad = 1'b0;
		for (k = 0; k < 40000 && done !== 1'b1; k++) begin
			if (meas === 1'b1) mn++;
			if (cal === 1'b1) cn++;
			if (cn > 0 && meas === 1'b1) bad = 1'b1;
			@(posedge clock_i);
			#1;
		end
		check(done, 1, "no done pulse");
		check(bad, 0, "calibration overlaps measure");
		check(mn, len, "measure length");
		check(cn, len, "calib length");
		check(busy, 0, "busy after done");
		@(posedge clock_i);
		#1;
	endtask : run_conv

	// Command from standby waits for the reference, then back to standby
	task automatic t_standby();
		int n;
		i_host.issue(amseq_pkg::amseq_cmd_t'(4'h6));
		wait_meas(n);
		check(n >= REFERENCE_HELD_STATE && n <= REFERENCE_HELD_STATE + 2, 1, "powerup delay");
		run_conv(0, 0);
		check(st, amseq_pkg::AMSEQ_STANDBY, "not standby");
	endtask : t_standby

	// Every mode from the held state, with a refused second command
	task automatic t_modes();
		int n;
		logic [2:0] s;
		logic [2:0] m;
		for (int i = 0; i < 8; i++) begin
			s = i[2:0];
			m = mode_tab[i];
			i_host.set_cfg({7'h00, s[2]}, 1'b1);
			i_host.issue(amseq_pkg::amseq_cmd_t'({s[1:0], ~s[0], s[0]}));
			wait_meas(n);
			check(n <= 1, 1, "held start late");
			check(busy, 1, "not busy in measure");
			check(cfg.mode, m, "mode decode");
			check(cfg.corner_hz, bw_tab[m], "corner");
			if (m == 3'h0) check(cfg.osr_exp, `AMSEQ_OSR_FAST, "osr");
			if (m == 3'h7) check(cfg.osr_exp, `AMSEQ_OSR_FILT, "osr");
			if (s[0]) check(conv_en, 3'h1, "gpio converters");
			else check(conv_en, 3'h7, "cell converters");
			i_host.set_cfg({7'h00, ~s[2]}, 1'b1);
			i_host.issue(amseq_pkg::amseq_cmd_t'({~s[1:0], 2'h2}));
			#1;
			check(cfg.mode, m, "mode not held");
			// Three measure cycles pass while the refused command goes out
			run_conv(m, 3);
			check(st, amseq_pkg::AMSEQ_REFHELD, "not held");
		end
	endtask : t_modes

	// Main sequence
	initial begin
		rstn_i = 1'b0;
		repeat (4) @(posedge clock_i);
		rstn_i <= 1'b1;
		#1;
		check(st, amseq_pkg::AMSEQ_STANDBY, "reset state");
		check({ref_on, conv_en, meas, cal, busy, done}, 0, "reset outs");
		t_standby();
		i_host.set_cfg(8'h00, 1'b1);
		repeat (REFERENCE_HELD_STATE + 4) @(posedge clock_i);
		#1;
		check(st, amseq_pkg::AMSEQ_REFHELD, "keep-on held");
		check(ref_on, 1, "reference off");
		t_modes();
		i_host.set_cfg(8'h00, 1'b0);
		repeat (4) @(posedge clock_i);
		#1;
		check(st, amseq_pkg::AMSEQ_STANDBY, "held not left");
		check(ref_on, 0, "reference kept");
		conclude();
	end

	// Watchdog well beyond the expected run of about 16500 cycles
	initial begin
		#400000;
		error_cnt++;
		conclude();
	end
endmodule : tb_top
